// ==== hdl/retimer_channel_eq_observe_regs.sv ====
// Register bank for one retimer channel: equalizer adaptation controls and observation.
// Assumes a single-master AHB-Lite bus on hclk; channel status inputs are asynchronous.
`timescale 1ns/1ps

module retimer_channel_eq_observe_regs
(
  // Clock and reset
  input  wire logic                                   hclk,
  input  wire logic                                   hresetn,
  // AHB-Lite slave
  input  wire logic                                   hsel,
  input  wire logic [31:0]                            haddr,
  input  wire logic [1:0]                             htrans,
  input  wire logic                                   hwrite,
  input  wire logic [2:0]                             hsize,
  input  wire logic [31:0]                            hwdata,
  input  wire logic                                   hready,
  output logic      [31:0]                            hrdata,
  output logic                                        hreadyout,
  output logic                                        hresp,
  // Channel status, asynchronous
  input  wire logic                                   signal_detect,
  input  wire logic                                   cdr_lock,
  input  wire logic                                   adapt_done,
  input  wire logic [15:0]                            freq_error_count,
  input  wire eq_observe_pkg::eq_state_type           eq_state,
  input  wire eq_observe_pkg::eye_pair_type           eye_normal,
  input  wire eq_observe_pkg::eye_pair_type           eye_alternate,
  input  wire logic                                   low_divide_ratio,
  input  wire logic                                   subrate_divide,
  input  wire logic                                   eye_interval_tick,
  // Equalizer table lookup by adaptation
  input  wire logic [3:0]                             table_index,
  output logic      [7:0]                             table_entry,
  // Controls to the channel
  output eq_observe_pkg::control_type                 control,
  output logic                                        adapt_allowed,
  output logic                                        eye_check_pulse,
  output logic      [7:0]                             eye_observe_horizontal,
  output logic      [7:0]                             eye_observe_vertical,
  output logic                                        lock_irq_flag,
  output logic                                        sig_detect_irq_flag
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  localparam int SYNC_W = 1 + 1 + 1 + 16 + 9 + 16 + 16 + 1 + 1 + 1;
  logic [SYNC_W-1:0] sync_a_reg;
  logic [SYNC_W-1:0] sync_b_reg;
  logic              sd_s;
  logic              lock_s;
  logic              done_s;
  logic [15:0]       ferr_s;
  eq_observe_pkg::eq_state_type eq_s;
  eq_observe_pkg::eye_pair_type eye_n_s;
  eq_observe_pkg::eye_pair_type eye_a_s;
  logic              low_div_s;
  logic              subrate_s;
  logic              tick_s;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync_a_reg <= '0;
      sync_b_reg <= '0;
    end
    else
    begin
      sync_a_reg <= {signal_detect, cdr_lock, adapt_done, freq_error_count, eq_state,
                     eye_normal, eye_alternate, low_divide_ratio, subrate_divide,
                     eye_interval_tick};
      sync_b_reg <= sync_a_reg;
    end
  end

  assign {sd_s, lock_s, done_s, ferr_s, eq_s, eye_n_s, eye_a_s, low_div_s, subrate_s,
          tick_s} = sync_b_reg;

  // ************************************************************
  // Bus address phase capture
  // ************************************************************
  logic       wr_pend_reg;
  logic       rd_pend_reg;
  logic [7:0] addr_reg;
  logic       accept;

  assign accept = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= accept && hwrite && (haddr[1:0] == 2'h0);
      rd_pend_reg <= accept && !hwrite;
      if (accept)
        addr_reg <= haddr[9:2];
    end
  end

  // Word index of register at byte offset; offsets are word indices, the bus byte address is four times
  logic [7:0] wdata;
  logic [7:0] widx;
  assign wdata = hwdata[7:0];
  assign widx  = addr_reg;

  // ************************************************************
  // Control registers
  // ************************************************************
  logic [7:0] start_index_reg;
  logic [7:0] fixed_boost_reg;
  logic [7:0] eye_mon_reg;
  logic [7:0] slicer_reg;
  logic [7:0] options_reg;
  logic [7:0] irq_en_reg;
  logic [7:0] rsvd_reg [4];
  logic [7:0] eq_table [16];
  logic [3:0] mag_next;

  // Magnitudes above the limit are clamped to the limit
  assign mag_next = (wdata[3:0] > eq_observe_pkg::SLICER_MAG_MAX) ?
                    eq_observe_pkg::SLICER_MAG_MAX : wdata[3:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      start_index_reg <= eq_observe_pkg::ADAPT_START_INDEX_RST;
      fixed_boost_reg <= eq_observe_pkg::FIXED_BOOST_RST;
      eye_mon_reg     <= eq_observe_pkg::EYE_MONITOR_ENABLE_RST;
      slicer_reg      <= eq_observe_pkg::SLICER_OFFSET_TRIM_RST;
      options_reg     <= eq_observe_pkg::OBSERVE_ADAPT_OPTIONS_RST;
      irq_en_reg      <= eq_observe_pkg::INTERRUPT_ENABLE_RST;
    end
    else if (wr_pend_reg)
    begin
      case (widx)
        eq_observe_pkg::ADAPT_START_INDEX_OFS:     start_index_reg <= wdata;
        eq_observe_pkg::FIXED_BOOST_LOW_RATES_OFS: fixed_boost_reg <= wdata;
        eq_observe_pkg::EYE_MONITOR_ENABLE_OFS:    eye_mon_reg     <= wdata;
        eq_observe_pkg::SLICER_OFFSET_TRIM_OFS:    slicer_reg <= {wdata[7:4], mag_next};
        eq_observe_pkg::OBSERVE_ADAPT_OPTIONS_OFS: options_reg     <= wdata;
        eq_observe_pkg::INTERRUPT_ENABLE_OFS:      irq_en_reg      <= wdata;
        default:                                   ;
      endcase
    end
  end

  // Reserved bytes simply hold what was written
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_rsvd
      localparam logic [7:0] OFS = (gi == 0) ? eq_observe_pkg::RESERVED_BYTE_A_OFS :
                                   (gi == 1) ? eq_observe_pkg::RESERVED_BYTE_B_OFS :
                                   (gi == 2) ? eq_observe_pkg::RESERVED_BYTE_C_OFS :
                                               eq_observe_pkg::RESERVED_BYTE_D_OFS;
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          rsvd_reg[gi] <= eq_observe_pkg::RESERVED_RST;
        else if (wr_pend_reg && widx == OFS)
          rsvd_reg[gi] <= wdata;
      end
    end
    for (gi = 0; gi < 16; gi++)
    begin : g_table
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          eq_table[gi] <= eq_observe_pkg::EQ_TABLE_RST;
        else if (wr_pend_reg && widx == eq_observe_pkg::EQ_TABLE_FIRST_OFS + 8'(gi))
          eq_table[gi] <= wdata;
      end
    end
  endgenerate

  // ************************************************************
  // Interrupt flags, set by status, cleared on read of detect_lock_status
  // ************************************************************
  logic lock_d_reg;
  logic sd_d_reg;
  logic lock_flag_reg;
  logic sd_flag_reg;
  logic status_read;

  assign status_read = rd_pend_reg && widx == eq_observe_pkg::DETECT_LOCK_STATUS_OFS;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lock_d_reg    <= 1'b0;
      sd_d_reg      <= 1'b0;
      lock_flag_reg <= 1'b0;
      sd_flag_reg   <= 1'b0;
    end
    else
    begin
      lock_d_reg <= lock_s;
      sd_d_reg   <= sd_s;
      // Set wins over the read clear
      if (irq_en_reg[eq_observe_pkg::LOCK_IRQ_EN_BIT] && lock_s && !lock_d_reg)
        lock_flag_reg <= 1'b1;
      else if (status_read || !irq_en_reg[eq_observe_pkg::LOCK_IRQ_EN_BIT])
        lock_flag_reg <= 1'b0;
      if (irq_en_reg[eq_observe_pkg::SIG_DETECT_IRQ_EN_BIT] && sd_s && !sd_d_reg)
        sd_flag_reg <= 1'b1;
      else if (status_read || !irq_en_reg[eq_observe_pkg::SIG_DETECT_IRQ_EN_BIT])
        sd_flag_reg <= 1'b0;
    end
  end

  // ************************************************************
  // Eye monitor scheduling
  // ************************************************************
  logic tick_d_reg;
  logic eye_pulse_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tick_d_reg    <= 1'b0;
      eye_pulse_reg <= 1'b0;
    end
    else
    begin
      tick_d_reg    <= tick_s;
      eye_pulse_reg <= eye_mon_reg[eq_observe_pkg::EYE_MONITOR_BIT] && lock_s && done_s &&
                       tick_s && !tick_d_reg;
    end
  end

  // ************************************************************
  // Read data and outputs
  // ************************************************************
  logic [7:0] status_byte;
  logic [7:0] rd_byte;
  eq_observe_pkg::eye_pair_type eye_sel;

  assign status_byte = {sd_s,
                        eq_s.eq_limit,
                        4'h0, lock_flag_reg, sd_flag_reg};
  assign eye_sel = options_reg[eq_observe_pkg::ALT_EYE_FOM_BIT] ? eye_a_s : eye_n_s;

  always_comb
  begin
    rd_byte = 8'h00;
    if (widx >= eq_observe_pkg::EQ_TABLE_FIRST_OFS && widx <= eq_observe_pkg::EQ_TABLE_LAST_OFS)
      rd_byte = eq_table[widx[3:0]];
    else
    begin
      case (widx)
        eq_observe_pkg::ADAPT_START_INDEX_OFS:     rd_byte = start_index_reg;
        eq_observe_pkg::FIXED_BOOST_LOW_RATES_OFS: rd_byte = fixed_boost_reg;
        eq_observe_pkg::FREQ_ERROR_COUNT_HIGH_OFS: rd_byte = ferr_s[15:8];
        eq_observe_pkg::FREQ_ERROR_COUNT_LOW_OFS:  rd_byte = ferr_s[7:0];
        eq_observe_pkg::RESERVED_BYTE_A_OFS:       rd_byte = rsvd_reg[0];
        eq_observe_pkg::EYE_MONITOR_ENABLE_OFS:    rd_byte = eye_mon_reg;
        eq_observe_pkg::RESERVED_BYTE_B_OFS:       rd_byte = rsvd_reg[1];
        eq_observe_pkg::SLICER_OFFSET_TRIM_OFS:    rd_byte = slicer_reg;
        eq_observe_pkg::RESERVED_BYTE_C_OFS:       rd_byte = rsvd_reg[2];
        eq_observe_pkg::BOOST_READBACK_OFS:        rd_byte = eq_s.boost;
        eq_observe_pkg::RESERVED_BYTE_D_OFS:       rd_byte = rsvd_reg[3];
        eq_observe_pkg::DETECT_LOCK_STATUS_OFS:    rd_byte = status_byte;
        eq_observe_pkg::OBSERVE_ADAPT_OPTIONS_OFS: rd_byte = options_reg;
        eq_observe_pkg::INTERRUPT_ENABLE_OFS:      rd_byte = irq_en_reg;
        default:                                   rd_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata                 <= 32'h0000_0000;
      hreadyout              <= 1'b1;
      hresp                  <= 1'b0;
      control                <= '0;
      adapt_allowed          <= 1'b0;
      eye_check_pulse        <= 1'b0;
      eye_observe_horizontal <= 8'h00;
      eye_observe_vertical   <= 8'h00;
      lock_irq_flag          <= 1'b0;
      sig_detect_irq_flag    <= 1'b0;
      table_entry            <= 8'h00;
    end
    else
    begin
      // Reads take one wait state so the data stands at the end of the data phase
      hreadyout <= !(accept && !hwrite);
      hresp     <= 1'b0;
      hrdata    <= accept ? 32'h0000_0000 : hrdata;
      if (rd_pend_reg)
        hrdata <= {24'h00_0000, rd_byte};
      control.start_index      <= start_index_reg[eq_observe_pkg::START_INDEX_MSB:0];
      control.stage0           <= fixed_boost_reg[7:6];
      control.stage1           <= fixed_boost_reg[5:4];
      control.stage2           <= fixed_boost_reg[3:2];
      control.stage3           <= fixed_boost_reg[1:0];
      control.eye_monitor_en   <= eye_mon_reg[eq_observe_pkg::EYE_MONITOR_BIT];
      control.slicer_sign      <= slicer_reg[eq_observe_pkg::SLICER_SIGN_BIT];
      control.slicer_mag       <= slicer_reg[eq_observe_pkg::SLICER_MAG_MSB:0];
      control.subrate_adapt_en <= options_reg[eq_observe_pkg::SUBRATE_ADAPT_BIT];
      control.alt_eye_fom      <= options_reg[eq_observe_pkg::ALT_EYE_FOM_BIT];
      adapt_allowed            <= !subrate_s ||
                                  options_reg[eq_observe_pkg::SUBRATE_ADAPT_BIT];
      eye_check_pulse          <= eye_pulse_reg;
      eye_observe_horizontal   <= eye_sel.horizontal_eye_opening;
      eye_observe_vertical     <= eye_sel.vertical_eye_opening;
      lock_irq_flag            <= lock_flag_reg;
      sig_detect_irq_flag      <= sd_flag_reg;
      table_entry              <= eq_table[table_index];
    end
  end

endmodule : retimer_channel_eq_observe_regs

// ==== hdl/eq_observe_pkg.sv ====
// Package for the retimer channel equalizer and observation register bank.
// Assumes an AHB-Lite slave; offsets below are word indices, byte address is four times.
package eq_observe_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] ADAPT_START_INDEX_OFS     = 8'h39;
  localparam logic [7:0] FIXED_BOOST_LOW_RATES_OFS = 8'h3A;
  localparam logic [7:0] FREQ_ERROR_COUNT_HIGH_OFS = 8'h3B;
  localparam logic [7:0] FREQ_ERROR_COUNT_LOW_OFS  = 8'h3C;
  localparam logic [7:0] RESERVED_BYTE_A_OFS       = 8'h3D;
  localparam logic [7:0] EYE_MONITOR_ENABLE_OFS    = 8'h3E;
  localparam logic [7:0] RESERVED_BYTE_B_OFS       = 8'h3F;
  localparam logic [7:0] EQ_TABLE_FIRST_OFS        = 8'h40;
  localparam logic [7:0] EQ_TABLE_LAST_OFS         = 8'h4F;
  localparam logic [7:0] SLICER_OFFSET_TRIM_OFS    = 8'h50;
  localparam logic [7:0] RESERVED_BYTE_C_OFS       = 8'h51;
  localparam logic [7:0] BOOST_READBACK_OFS        = 8'h52;
  localparam logic [7:0] RESERVED_BYTE_D_OFS       = 8'h53;
  localparam logic [7:0] DETECT_LOCK_STATUS_OFS    = 8'h54;
  localparam logic [7:0] OBSERVE_ADAPT_OPTIONS_OFS = 8'h55;
  localparam logic [7:0] INTERRUPT_ENABLE_OFS      = 8'h56;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] ADAPT_START_INDEX_RST     = 8'h00;
  localparam logic [7:0] FIXED_BOOST_RST           = 8'h00;
  localparam logic [7:0] EYE_MONITOR_ENABLE_RST    = 8'h80;
  localparam logic [7:0] SLICER_OFFSET_TRIM_RST    = 8'h00;
  localparam logic [7:0] OBSERVE_ADAPT_OPTIONS_RST = 8'h00;
  localparam logic [7:0] INTERRUPT_ENABLE_RST      = 8'h00;
  localparam logic [7:0] RESERVED_RST              = 8'h00;
  localparam logic [7:0] EQ_TABLE_RST              = 8'h00;

  // ************************************************************
  // Field positions and limits
  // ************************************************************
  localparam int         START_INDEX_MSB     = 4;
  localparam int         EYE_MONITOR_BIT     = 7;
  localparam int         SLICER_SIGN_BIT     = 4;
  localparam int         SLICER_MAG_MSB      = 3;
  localparam logic [3:0] SLICER_MAG_MAX      = 4'hA;
  localparam int         SLICER_STEP_MV      = 5;
  localparam int         SIG_DETECT_BIT      = 7;
  localparam int         EQ_LIMIT_BIT        = 6;
  localparam int         LOCK_IRQ_BIT        = 1;
  localparam int         SIG_DETECT_IRQ_BIT  = 0;
  localparam int         ALT_EYE_FOM_BIT     = 4;
  localparam int         SUBRATE_ADAPT_BIT   = 0;
  localparam int         LOCK_IRQ_EN_BIT     = 3;
  localparam int         SIG_DETECT_IRQ_EN_BIT = 2;
  localparam int         STAGE3_LIMIT_BIT    = 2;

  // ************************************************************
  // AHB encodings
  // ************************************************************
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic [7:0] boost;
    logic       eq_limit;
  } eq_state_type;

  typedef struct packed {
    logic [7:0] horizontal_eye_opening;
    logic [7:0] vertical_eye_opening;
  } eye_pair_type;

  typedef struct packed {
    logic [4:0] start_index;
    logic [1:0] stage0;
    logic [1:0] stage1;
    logic [1:0] stage2;
    logic [1:0] stage3;
    logic       eye_monitor_en;
    logic       slicer_sign;
    logic [3:0] slicer_mag;
    logic       subrate_adapt_en;
    logic       alt_eye_fom;
  } control_type;

endpackage : eq_observe_pkg

// ==== tb/retimer_channel_eq_observe_properties.sv ====
// Checker for the equalizer observation register bank.
// Assumes it is bound to the bank and sees only its ports; reads take one wait state.
`timescale 1ns/1ps

module retimer_channel_eq_observe_properties
(
  // Clock and reset
  input wire logic                        hclk,
  input wire logic                        hresetn,
  // Bus
  input wire logic                        hsel,
  input wire logic [31:0]                 haddr,
  input wire logic [1:0]                  htrans,
  input wire logic                        hwrite,
  input wire logic [31:0]                 hwdata,
  input wire logic                        hready,
  input wire logic [31:0]                 hrdata,
  input wire logic                        hreadyout,
  input wire logic                        hresp,
  // Channel side
  input wire logic                        signal_detect,
  input wire logic                        cdr_lock,
  input wire logic                        adapt_done,
  input wire eq_observe_pkg::eq_state_type eq_state,
  input wire logic                        subrate_divide,
  input wire eq_observe_pkg::control_type control,
  input wire logic                        adapt_allowed,
  input wire logic                        eye_check_pulse,
  input wire logic                        lock_irq_flag
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ************************************************************
  // Bus phases
  // ************************************************************
  sequence s_wr(logic [7:0] ofs);
    hsel && hready && htrans[1] && hwrite && haddr == {22'h0, ofs, 2'h0};
  endsequence
  sequence s_rd(logic [7:0] ofs);
    hsel && hready && htrans[1] && !hwrite && haddr == {22'h0, ofs, 2'h0};
  endsequence

  // ************************************************************
  // Assertions
  // ************************************************************
  a_start_index: assert property (s_wr(8'h39) |-> ##3
    control.start_index == $past(hwdata[4:0], 2))
    else $error("start index not applied");
  a_stage_map: assert property (s_wr(8'h3A) |-> ##3
    {control.stage0, control.stage1, control.stage2, control.stage3} == $past(hwdata[7:0], 2))
    else $error("fixed boost stages misplaced");
  a_eye_enable: assert property (s_wr(8'h3E) |-> ##3
    control.eye_monitor_en == $past(hwdata[7], 2))
    else $error("eye monitor enable not applied");
  a_slicer_clamp: assert property (s_wr(8'h50) |-> ##3
    control.slicer_sign == $past(hwdata[4], 2)
    && control.slicer_mag == ($past(hwdata[3:0], 2) > 4'hA ? 4'hA : $past(hwdata[3:0], 2)))
    else $error("slicer trim wrong");
  a_adapt_gate: assert property (
    (subrate_divide && !control.subrate_adapt_en)[*5] |-> !adapt_allowed)
    else $error("sub-rate adaptation not blocked");
  a_lock_flag: assert property ($rose(lock_irq_flag) |-> $past(cdr_lock, 4))
    else $error("lock flag without lock");
  a_detect_bit: assert property ($stable(signal_detect)[*6] ##0 s_rd(8'h54) |-> ##2
    hrdata[7] == $past(signal_detect, 2))
    else $error("signal detect bit wrong");
  a_boost_read: assert property ($stable(eq_state)[*6] ##0 s_rd(8'h52) |-> ##2
    hrdata == {24'h0, $past(eq_state.boost, 2)})
    else $error("boost readback wrong");
  a_eye_pulse: assert property (eye_check_pulse |->
    $past(cdr_lock, 4) && $past(adapt_done, 4) ##1 !eye_check_pulse)
    else $error("eye check pulse wrong");
  a_bus_okay: assert property (!hresp)
    else $error("bus response not OKAY");
  a_wait_single: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
endmodule : retimer_channel_eq_observe_properties

bind retimer_channel_eq_observe_regs retimer_channel_eq_observe_properties
  retimer_channel_eq_observe_properties_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hrdata, .hreadyout, .hresp, .signal_detect, .cdr_lock, .adapt_done,
  .eq_state, .subrate_divide, .control, .adapt_allowed, .eye_check_pulse, .lock_irq_flag);

// ==== tb/test_retimer_channel_eq_observe_regs.sv ====
// Testbench for the equalizer observation register bank.
// Assumes the slave may insert wait states; registers sit at byte address four times offset.
`timescale 1ns/1ps

module test_retimer_channel_eq_observe_regs;
  // ************************************************************
  // Signals
  // ************************************************************
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [1:0]  htrans = 2'h0;
  logic        hreadyout, hresp, signal_detect = 1'b0, cdr_lock = 1'b0, adapt_done = 1'b0;
  logic        low_divide_ratio = 1'b0, subrate_divide = 1'b0, eye_interval_tick = 1'b0;
  logic [15:0] freq_error_count = 16'h0;
  logic [3:0]  table_index = 4'h0;
  logic [7:0]  table_entry, eye_observe_horizontal, eye_observe_vertical, d;
  logic        adapt_allowed, eye_check_pulse, lock_irq_flag, sig_detect_irq_flag;
  wire logic   hready;
  eq_observe_pkg::eq_state_type eq_state = '0;
  eq_observe_pkg::eye_pair_type eye_normal = '0, eye_alternate = '0;
  eq_observe_pkg::control_type  control;
  int n_errors = 0, n_tests = 0, n_pulse = 0, i;
  logic [7:0] rst_ofs [14] = '{8'h39, 8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'h3E, 8'h3F,
                               8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56};
  logic [7:0] trim [4] = '{8'h15, 8'h1A, 8'h0B, 8'h1F};

  assign hready = hreadyout;
  always #25 hclk = ~hclk;
  always @(posedge hclk) if (eye_check_pulse === 1'b1) n_pulse++;

  retimer_channel_eq_observe_regs retimer_channel_eq_observe_regs_inst (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize(eq_observe_pkg::HSIZE_WORD), .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .signal_detect, .cdr_lock, .adapt_done, .freq_error_count, .eq_state,
    .eye_normal, .eye_alternate, .low_divide_ratio, .subrate_divide, .eye_interval_tick,
    .table_index, .table_entry, .control, .adapt_allowed, .eye_check_pulse,
    .eye_observe_horizontal, .eye_observe_vertical, .lock_irq_flag, .sig_detect_irq_flag);

  // ************************************************************
  // Tasks
  // ************************************************************
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task xfer(input logic w, input logic [7:0] ofs, input logic [7:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, ofs, 2'h0};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    // Read data is taken at the edge that ends the data phase
    q = hrdata;
  endtask : xfer

  task wr(input logic [7:0] ofs, input logic [7:0] wd);
    xfer(1'b1, ofs, wd);
  endtask : wr

  task rc(input string what, input logic [7:0] ofs, input logic [31:0] exp);
    xfer(1'b0, ofs, 8'h00);
    chk(what, q, exp);
  endtask : rc

  task settle;
    repeat (6) @(negedge hclk);
  endtask : settle

  task test_done;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  initial
  begin
    #2000000;
    n_errors++;
    test_done();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    chk("control reset", control, 32'h80);
    for (i = 0; i < 14; i++)
      rc("reset value", rst_ofs[i], rst_ofs[i] == 8'h3E ? 32'h80 : 32'h0);
    wr(8'h30, 8'hFF);
    rc("unmapped", 8'h30, 32'h0);
    $display("test reset done");

    wr(8'h39, 8'hFF);
    wr(8'h3A, 8'hE4);
    wr(8'h3E, 8'h00);
    wr(8'h52, 8'hFF);
    settle();
    chk("start index", control.start_index, 32'h1F);
    d = {control.stage0, control.stage1, control.stage2, control.stage3};
    chk("stages", d, 32'hE4);
    chk("eye enable", control.eye_monitor_en, 32'h0);
    rc("start reg", 8'h39, 32'hFF);
    rc("boost reg", 8'h3A, 32'hE4);
    rc("read only", 8'h52, 32'h0);
    for (i = 0; i < 4; i++)
    begin
      d = trim[i];
      wr(8'h50, d);
      settle();
      chk("slicer", {control.slicer_sign, control.slicer_mag},
          {d[4], d[3:0] > 4'hA ? 4'hA : d[3:0]});
    end
    $display("test controls done");

    for (i = 0; i < 16; i++)
      wr(8'h40 + i[7:0], 8'hA0 + i[7:0]);
    for (i = 0; i < 16; i++)
    begin
      rc("table read", 8'h40 + i[7:0], 32'hA0 + i);
      @(posedge hclk);
      table_index <= i[3:0];
      settle();
      chk("table entry", table_entry, 32'hA0 + i);
    end
    $display("test table done");

    @(posedge hclk);
    freq_error_count <= 16'hA55A;
    eq_state <= '{boost: 8'h3C, eq_limit: 1'b1};
    signal_detect <= 1'b1;
    cdr_lock <= 1'b1;
    settle();
    rc("count high", 8'h3B, 32'hA5);
    rc("count low", 8'h3C, 32'h5A);
    rc("boost", 8'h52, 32'h3C);
    rc("status", 8'h54, 32'hC0);
    chk("lock flag off", lock_irq_flag, 32'h0);
    chk("detect flag off", sig_detect_irq_flag, 32'h0);
    @(posedge hclk);
    signal_detect <= 1'b0;
    cdr_lock <= 1'b0;
    wr(8'h56, 8'h0C);
    settle();
    @(posedge hclk);
    signal_detect <= 1'b1;
    cdr_lock <= 1'b1;
    settle();
    chk("lock flag", lock_irq_flag, 32'h1);
    chk("detect flag", sig_detect_irq_flag, 32'h1);
    rc("status flags", 8'h54, 32'hC3);
    settle();
    chk("lock flag cleared", lock_irq_flag, 32'h0);
    $display("test status done");

    @(posedge hclk);
    eye_normal <= 16'h1122;
    eye_alternate <= 16'h3344;
    subrate_divide <= 1'b1;
    low_divide_ratio <= 1'b1;
    settle();
    chk("eye normal", {eye_observe_horizontal, eye_observe_vertical}, 32'h1122);
    chk("subrate blocked", adapt_allowed, 32'h0);
    wr(8'h55, 8'h11);
    settle();
    chk("eye alternate", {eye_observe_horizontal, eye_observe_vertical}, 32'h3344);
    chk("subrate allowed", adapt_allowed, 32'h1);
    @(posedge hclk);
    subrate_divide <= 1'b0;
    wr(8'h55, 8'h00);
    settle();
    chk("full rate", adapt_allowed, 32'h1);
    $display("test select done");

    @(posedge hclk);
    adapt_done <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      if (i == 2)
        wr(8'h3E, 8'h80);
      @(posedge hclk);
      eye_interval_tick <= 1'b1;
      settle();
      @(posedge hclk);
      eye_interval_tick <= 1'b0;
      settle();
    end
    chk("eye pulses", n_pulse, 32'h2);
    $display("test eye done");
    test_done();
  end
endmodule : test_retimer_channel_eq_observe_regs
